// ### hw/iam_map.svh
// register offsets, bit positions, reset values and timing constants of the monitor
`ifndef IAM_MAP_SVH
`define IAM_MAP_SVH

`define IAM_CTRL_PORT 16'hB072

`define IAM_BIT_REQ_EN 15
`define IAM_BIT_STAGE12 14
`define IAM_BIT_TEST 13
`define IAM_BIT_LATCH 12
`define IAM_BIT_INACT 11
`define IAM_BIT_AFTER 10
`define IAM_BIT_BEFORE 9
`define IAM_BIT_ENABLE 8
`define IAM_COARSE_HI 7
`define IAM_COARSE_LO 4
`define IAM_FINE_HI 3
`define IAM_FINE_LO 0

`define IAM_CNT_W 17
`define IAM_STAGE12_IDX 11
`define IAM_BYPASS_STAGES 9
`define IAM_COARSE_SHIFT 13

`define IAM_CTRL_RESET 16'h0000
`define IAM_RDATA_UNMAPPED 16'h0000

`define IAM_CLK_PERIOD_PS 4000
`define IAM_FINE_UNIT_PS 64'd7812500000
`define IAM_FINE_UNIT_CYCLES (`IAM_FINE_UNIT_PS / `IAM_CLK_PERIOD_PS)
`define IAM_TEST_UNIT_CYCLES (`IAM_FINE_UNIT_CYCLES >> `IAM_BYPASS_STAGES)

`endif

// ### hw/iam_pkg.sv
// types shared by the inactivity monitor files
`include "iam_map.svh"

package iam_pkg;

    typedef enum logic {
        IAM_IDLE,
        IAM_COUNTING
    } iam_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } iam_io_req_s;

    typedef struct packed {
        logic request_activity_enable;
        logic monitor_test_speedup;
        logic monitor_master_enable;
        logic [3:0] coarse_timeout_field;
        logic [3:0] fine_timeout_field;
    } iam_ctrl_s;

    typedef struct packed {
        logic activity_latch;
        logic inactivity_flag;
        logic activity_after_flag;
        logic activity_before_flag;
    } iam_flags_s;

    typedef logic [`IAM_CNT_W-1:0] iam_count_t;

endpackage

// ### hw/iam_prescale.sv
// restartable prescaler giving one tick per timeout unit, fast divide in test mode
`timescale 1ns/1ps

module iam_prescale #(
    parameter int unsigned NORMAL_CYCLES = 1953125,
    parameter int unsigned TEST_CYCLES = 3814
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic restart,
    input wire logic fast,
    output logic tick
);

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } iam_pre_state_s;

    iam_pre_state_s s_q;
    iam_pre_state_s s_d;
    logic [31:0] last;

    always_comb begin
        s_d = s_q;
        last = fast ? (TEST_CYCLES - 32'd1) : (NORMAL_CYCLES - 32'd1);
        s_d.tick = 1'b0;
        if (restart) begin
            // restart keeps the first unit whole, so delays never come out short
            s_d.cnt = 32'h0000_0000;
        end else if (s_q.cnt >= last) begin
            s_d.cnt = 32'h0000_0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'd1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule // iam_prescale

// ### hw/iam_monitor.sv
// inactivity timeout monitor: control port, timeout counter and activity flags
`timescale 1ns/1ps

`include "iam_map.svh"

module iam_monitor #(
    parameter longint unsigned FINE_UNIT_CYCLES = `IAM_FINE_UNIT_CYCLES,
    parameter longint unsigned TEST_UNIT_CYCLES = `IAM_TEST_UNIT_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire iam_pkg::iam_io_req_s io_req,
    input wire logic request_activity_pulse,
    input wire logic other_activity_pulse,
    output logic [15:0] io_rdata,
    output logic local_attention_out,
    output logic monitor_counting
);

    typedef struct packed {
        iam_pkg::iam_state_e fsm;
        iam_pkg::iam_ctrl_s ctrl;
        iam_pkg::iam_flags_s flags;
        iam_pkg::iam_count_t cnt;
        logic [15:0] rdata;
        logic attention;
    } iam_state_s;

    iam_state_s s_q;
    iam_state_s s_d;

    logic hit;
    logic wr_ctrl;
    logic rd_ctrl;
    logic activity;
    logic tick;
    logic restart;
    logic timeout;
    iam_pkg::iam_count_t target;
    iam_pkg::iam_count_t cnt_next;

    // single decode used by both read and write paths
    function automatic logic port_hit(input logic [15:0] addr);
        port_hit = (addr == `IAM_CTRL_PORT);
    endfunction

    // coarse unit is 8192 fine units, so the sum is one concatenation
    function automatic iam_pkg::iam_count_t full_target(input iam_pkg::iam_ctrl_s c);
        full_target = {c.coarse_timeout_field, `IAM_COARSE_SHIFT'(0)}
            + iam_pkg::iam_count_t'(c.fine_timeout_field);
    endfunction

    function automatic logic [15:0] ctrl_image(input iam_state_s s);
        logic [15:0] v;
        v = 16'h0000;
        v[`IAM_BIT_REQ_EN] = s.ctrl.request_activity_enable;
        v[`IAM_BIT_STAGE12] = s.cnt[`IAM_STAGE12_IDX];
        v[`IAM_BIT_TEST] = s.ctrl.monitor_test_speedup;
        v[`IAM_BIT_LATCH] = s.flags.activity_latch;
        v[`IAM_BIT_INACT] = s.flags.inactivity_flag;
        v[`IAM_BIT_AFTER] = s.flags.activity_after_flag;
        v[`IAM_BIT_BEFORE] = s.flags.activity_before_flag;
        v[`IAM_BIT_ENABLE] = s.ctrl.monitor_master_enable;
        v[`IAM_COARSE_HI:`IAM_COARSE_LO] = s.ctrl.coarse_timeout_field;
        v[`IAM_FINE_HI:`IAM_FINE_LO] = s.ctrl.fine_timeout_field;
        ctrl_image = v;
    endfunction

    always_comb begin
        hit = port_hit(io_req.addr);
        wr_ctrl = io_req.wr && hit;
        rd_ctrl = io_req.rd && hit;
    end

    // inputs come from logic on mclk, so no synchronisers
    always_comb begin
        activity = other_activity_pulse;
        if (s_q.ctrl.request_activity_enable) begin
            activity = other_activity_pulse || request_activity_pulse;
        end
    end

    // test mode drops the nine low stages, fine field wholly lost there
    always_comb begin
        target = full_target(s_q.ctrl);
        if (s_q.ctrl.monitor_test_speedup) begin
            target = target >> `IAM_BYPASS_STAGES;
        end
    end

    always_comb begin
        cnt_next = s_q.cnt + iam_pkg::iam_count_t'(1);
        // zero target fires at once; nonzero fires after exactly target units
        timeout = (s_q.fsm == iam_pkg::IAM_COUNTING) && !activity
            && ((target == '0) || (tick && (cnt_next >= target)));
        restart = (s_q.fsm != iam_pkg::IAM_COUNTING) || activity || timeout;
    end

    iam_prescale #(
        .NORMAL_CYCLES(32'(FINE_UNIT_CYCLES)),
        .TEST_CYCLES(32'(TEST_UNIT_CYCLES))
    ) u_prescale (
        .mclk(mclk),
        .srst(srst),
        .restart(restart),
        .fast(s_q.ctrl.monitor_test_speedup),
        .tick(tick)
    );

    always_comb begin
        s_d = s_q;
        s_d.attention = 1'b0;

        // register writes first; hardware sets below win over a cleared bit, but a disabling write still clears flags 11:9
        if (wr_ctrl) begin
            s_d.ctrl.request_activity_enable = io_req.wdata[`IAM_BIT_REQ_EN];
            s_d.ctrl.monitor_test_speedup = io_req.wdata[`IAM_BIT_TEST];
            s_d.ctrl.monitor_master_enable = io_req.wdata[`IAM_BIT_ENABLE];
            // field changes while enabled take effect at once; software must avoid it
            s_d.ctrl.coarse_timeout_field = io_req.wdata[`IAM_COARSE_HI:`IAM_COARSE_LO];
            s_d.ctrl.fine_timeout_field = io_req.wdata[`IAM_FINE_HI:`IAM_FINE_LO];
            if (!io_req.wdata[`IAM_BIT_LATCH]) begin
                s_d.flags.activity_latch = 1'b0;
            end
            if (!io_req.wdata[`IAM_BIT_INACT] || !io_req.wdata[`IAM_BIT_ENABLE]) begin
                s_d.flags.inactivity_flag = 1'b0;
                s_d.flags.activity_after_flag = 1'b0;
                s_d.flags.activity_before_flag = 1'b0;
            end
        end

        if (activity) begin
            s_d.flags.activity_latch = 1'b1;
        end

        case (s_q.fsm)
            iam_pkg::IAM_IDLE: begin
                s_d.cnt = '0;
                if (s_q.ctrl.monitor_master_enable) begin
                    s_d.fsm = iam_pkg::IAM_COUNTING;
                end
            end
            iam_pkg::IAM_COUNTING: begin
                if (!s_q.ctrl.monitor_master_enable) begin
                    s_d.fsm = iam_pkg::IAM_IDLE;
                    s_d.cnt = '0;
                end else if (activity) begin
                    s_d.cnt = '0;
                    if (s_q.flags.inactivity_flag) begin
                        s_d.flags.activity_after_flag = 1'b1;
                    end else begin
                        s_d.flags.activity_before_flag = 1'b1;
                    end
                end else if (timeout) begin
                    s_d.cnt = '0;
                    s_d.flags.inactivity_flag = 1'b1;
                    s_d.attention = 1'b1;
                end else if (tick) begin
                    s_d.cnt = cnt_next;
                end
            end
            default: begin
                s_d.fsm = iam_pkg::IAM_IDLE;
            end
        endcase

        // a write that turns the monitor off drops it to idle the next cycle
        if (wr_ctrl && !io_req.wdata[`IAM_BIT_ENABLE]) begin
            s_d.fsm = iam_pkg::IAM_IDLE;
            s_d.cnt = '0;
            // disabling beats an activity or timeout landing in the same cycle for flags 11:9; a timeout's attention pulse still goes out
            s_d.flags.inactivity_flag = 1'b0;
            s_d.flags.activity_after_flag = 1'b0;
            s_d.flags.activity_before_flag = 1'b0;
        end

        if (rd_ctrl) begin
            s_d.rdata = ctrl_image(s_q);
        end else if (io_req.rd) begin
            s_d.rdata = `IAM_RDATA_UNMAPPED;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q.fsm <= iam_pkg::IAM_IDLE;
            s_q.ctrl <= '0;
            s_q.flags <= '0;
            s_q.cnt <= '0;
            s_q.rdata <= `IAM_CTRL_RESET;
            s_q.attention <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata = s_q.rdata;
    assign local_attention_out = s_q.attention;
    assign monitor_counting = (s_q.fsm == iam_pkg::IAM_COUNTING);

endmodule // iam_monitor

// ### verif/iam_chk.sv
// port assertions for the inactivity monitor
`timescale 1ns/1ps
`include "iam_map.svh"
module iam_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire iam_pkg::iam_io_req_s io_req,
    input wire logic request_activity_pulse,
    input wire logic other_activity_pulse,
    input wire logic [15:0] io_rdata,
    input wire logic local_attention_out,
    input wire logic monitor_counting
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic hit = io_req.addr == `IAM_CTRL_PORT;
    sequence wr_s; io_req.wr && hit; endsequence
    sequence rd_s; io_req.rd && hit; endsequence
    sequence off_s; io_req.wr && hit && !io_req.wdata[8]; endsequence
    reset_outs_a: assert property (disable iff (1'b0) srst |=>
        io_rdata == 16'h0000 && !local_attention_out && !monitor_counting)
        else $error("outputs not cleared by reset");
    rdata_hold_a: assert property (!io_req.rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (io_req.rd && !hit |=> io_rdata == 16'h0000)
        else $error("unmapped read not zero");
    enable_start_a: assert property (wr_s ##0 io_req.wdata[8] |-> ##2 monitor_counting)
        else $error("enable did not start counting");
    disable_idle_a: assert property (off_s |-> ##[1:2] !monitor_counting)
        else $error("disable did not stop counting");
    attn_counting_a: assert property (local_attention_out |-> $past(monitor_counting))
        else $error("attention while idle");
    rw_image_a: assert property (wr_s ##2 rd_s |=>
        (io_rdata & 16'hA1FF) == ($past(io_req.wdata, 3) & 16'hA1FF))
        else $error("writable bits not read back");
    flags_clear_a: assert property (off_s ##2 rd_s |=> io_rdata[11:8] == 4'h0)
        else $error("flags survive disable");
    latch_set_a: assert property (other_activity_pulse ##1 rd_s |=> io_rdata[12])
        else $error("activity latch not set");
endmodule // iam_chk

bind iam_monitor iam_chk u_chk (.mclk(mclk), .srst(srst), .io_req(io_req),
    .request_activity_pulse(request_activity_pulse), .other_activity_pulse(other_activity_pulse),
    .io_rdata(io_rdata), .local_attention_out(local_attention_out),
    .monitor_counting(monitor_counting));

// ### verif/iam_act_src.sv
// activity source model: turns requests into activity pulses one cycle later
`timescale 1ns/1ps
module iam_act_src (
    input wire logic mclk,
    input wire logic fire_req,
    input wire logic fire_oth,
    output logic request_activity_pulse,
    output logic other_activity_pulse
);
    // line masks live upstream, so pulses arrive already qualified
    initial request_activity_pulse = 1'b0;
    initial other_activity_pulse = 1'b0;
    always @(posedge mclk) begin
        request_activity_pulse <= fire_req;
        other_activity_pulse <= fire_oth;
    end
endmodule // iam_act_src

// ### verif/test_inactivity_timeout_monitor.sv
// self-checking bench for the inactivity monitor
`timescale 1ns/1ps
`include "iam_map.svh"
module test_inactivity_timeout_monitor;
    localparam int FU = 20;
    localparam int TU = 4;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    iam_pkg::iam_io_req_s io = '0;
    logic fire_req = 1'b0;
    logic fire_oth = 1'b0;
    logic req_p, oth_p, attn, cnt;
    logic [15:0] rdata;
    integer bad_count = 0;
    integer check_count = 0;
    integer m = 0;
    integer seed = 20;
    integer i, n, f;
    iam_act_src src (.mclk(mclk), .fire_req(fire_req), .fire_oth(fire_oth),
        .request_activity_pulse(req_p), .other_activity_pulse(oth_p));
    iam_monitor #(.FINE_UNIT_CYCLES(FU), .TEST_UNIT_CYCLES(TU)) dut (.mclk(mclk), .srst(srst),
        .io_req(io), .request_activity_pulse(req_p), .other_activity_pulse(oth_p),
        .io_rdata(rdata), .local_attention_out(attn), .monitor_counting(cnt));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // model image follows each write: flags kept unless cleared, latch only cleared by 0
    task wr(input logic [15:0] d);
        @(posedge mclk);
        io.wr <= 1'b1;
        io.addr <= `IAM_CTRL_PORT;
        io.wdata <= d;
        @(posedge mclk);
        io.wr <= 1'b0;
        if (!d[11] || !d[8]) m = m & 32'hF1FF;
        m = (m & 32'h1E00 & {19'h0, d[12], 12'hFFF}) | (d & 16'hA1FF);
    endtask
    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk);
        io.rd <= 1'b1;
        io.addr <= a;
        @(posedge mclk);
        io.rd <= 1'b0;
        #1 chk("io_rdata", rdata, e);
    endtask
    task act(input logic r);
        @(posedge mclk);
        fire_req <= r;
        fire_oth <= !r;
        @(posedge mclk);
        fire_req <= 1'b0;
        fire_oth <= 1'b0;
        if (!r || m[15]) begin
            m = m | 32'h1000;
            if (m[8]) m = m | (m[11] ? 32'h0400 : 32'h0200);
        end
    endtask
    // waits for attention; optional activity pulse at cycle a restarts the count
    task wt(input integer t, input integer a, input integer s);
        n = 0;
        do begin
            @(posedge mclk);
            fire_oth <= (n + 1 == a);
            #1;
            n++;
        end while (attn !== 1'b1 && n < 4000);
        if (a > 0) m = m | 32'h1200;
        m = m | 32'h0800;
        chk("timeout_delay", 32'(n >= t + a && n <= t + a + s), 32'h1);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rd(`IAM_CTRL_PORT, 16'h0000);
        rd(16'($random(seed)) | 16'h0001, 16'h0000);
        wr(16'hFFFF);
        rd(`IAM_CTRL_PORT, m[15:0]);
        chk("monitor_counting", cnt, 32'h1);
        wr(16'h0000);
        #1 chk("monitor_counting", cnt, 32'h0);
        act(1'b1);
        rd(`IAM_CTRL_PORT, m[15:0]);
        act(1'b0);
        rd(`IAM_CTRL_PORT, m[15:0]);
        wr(16'h8000);
        act(1'b1);
        wr(16'h9000);
        rd(`IAM_CTRL_PORT, m[15:0]);
        wr(16'h0000);
        for (i = 0; i < 3; i++) begin
            f = 1 + ($random(seed) & 3);
            wr(16'h0100 | 16'(f));
            wt(f * FU, (i == 1) ? f * FU / 2 : 0, FU / 2 + 5);
            rd(`IAM_CTRL_PORT, m[15:0]);
            act(1'b0);
            rd(`IAM_CTRL_PORT, m[15:0]);
            wr(16'h0100 | 16'(f));
            rd(`IAM_CTRL_PORT, m[15:0]);
            wr(16'h0000);
        end
        // counter passes 2048 units well before the 8192-unit timeout
        wr(16'h0110);
        repeat (2100 * FU) @(posedge mclk);
        rd(`IAM_CTRL_PORT, m[15:0] | 16'h4000);
        wr(16'h0000);
        wr(16'h2110);
        wt(16 * TU, 0, TU / 2 + 5);
        wt(16 * TU, 0, TU / 2 + 5);
        rd(`IAM_CTRL_PORT, m[15:0]);
        wr(16'h0000);
        rd(`IAM_CTRL_PORT, 16'h0000);
        test_done;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        test_done;
    end
endmodule // test_inactivity_timeout_monitor
